// ### sync_monitor_pkg.sv
// Shared constants for the receive sync monitor
package sync_monitor_pkg;
    // ==========================================================
    // Timing
    localparam int unsigned CLOCK_HZ        = 25_000_000;
    localparam int unsigned IDLE_TIMEOUT_S  = 10;
    localparam int unsigned CLK_LOSS_MS     = 50;
    localparam int unsigned SNAP_PERIOD_S   = 2;
    localparam int unsigned IDLE_CYCLES     = IDLE_TIMEOUT_S * CLOCK_HZ;
    localparam int unsigned CLK_LOSS_CYCLES = (CLK_LOSS_MS * CLOCK_HZ) / 1000;
    localparam int unsigned SNAP_CYCLES     = SNAP_PERIOD_S * CLOCK_HZ;
    localparam int unsigned IDLE_W          = 28;
    localparam int unsigned CLKLOSS_W       = 21;
    localparam int unsigned SNAP_W          = 26;
    // ==========================================================
    // Byte-count sync threshold
    localparam int unsigned THR_W           = 12;
    localparam logic [11:0] BYTE_THR_MIN    = 12'h00a;
    localparam logic [11:0] BYTE_THR_MAX    = 12'h800;
    // ==========================================================
    // Snapshot history
    localparam int unsigned RESULT_W        = 32;
    localparam int unsigned HIST_DEPTH      = 2;
    localparam logic [31:0] RESULT_RESET    = 32'h0000_0000;
endpackage

// ### snapshot_mem.sv
// Small result history memory with registered read data
`timescale 1ns/100ps
`default_nettype none
module snapshot_mem #(
    parameter int unsigned WIDTH = 32,
    parameter int unsigned DEPTH = 2,
    parameter int unsigned AW    = (DEPTH > 1) ? $clog2(DEPTH) : 1
) (
    input  wire logic             clock_in,
    input  wire logic             wr_en_in,
    input  wire logic [AW-1:0]    wr_addr_in,
    input  wire logic [WIDTH-1:0] wr_data_in,
    input  wire logic [AW-1:0]    rd_addr_in,
    output logic      [WIDTH-1:0] rd_data_out
);
    logic [WIDTH-1:0] mem_ff [DEPTH];

    always_ff @(posedge clock_in)
    begin
        if (wr_en_in)
        begin
            mem_ff[wr_addr_in] <= wr_data_in;
        end
        rd_data_out <= mem_ff[rd_addr_in];
    end
endmodule
`default_nettype wire

// ### receive_sync_monitor.sv
// Receive sync monitor: sync threshold, loss detection, indicators, pre-loss snapshot
`timescale 1ns/100ps
`default_nettype none
module receive_sync_monitor #(
    parameter int unsigned IDLE_LIMIT = sync_monitor_pkg::IDLE_CYCLES,
    parameter int unsigned CLK_LIMIT  = sync_monitor_pkg::CLK_LOSS_CYCLES,
    parameter int unsigned SNAP_LIMIT = sync_monitor_pkg::SNAP_CYCLES
) (
    input  wire logic                              clock_in,
    input  wire logic                              rstn_in,
    input  wire logic                              rx_data_in,
    input  wire logic                              rx_clock_in,
    input  wire logic                              rx_char_in,
    input  wire logic                              byte_valid_in,
    input  wire logic                              byte_error_in,
    input  wire logic                              user_sync_mode_in,
    input  wire logic                              whole_pattern_threshold_in,
    input  wire logic [sync_monitor_pkg::THR_W-1:0] user_pattern_sync_threshold_in,
    input  wire logic [sync_monitor_pkg::THR_W-1:0] pattern_length_in,
    input  wire logic                              pattern_sync_in,
    input  wire logic                              async_mode_in,
    input  wire logic                              idle_data_timeout_in,
    input  wire logic                              clock_required_in,
    input  wire logic                              power_loss_in,
    input  wire logic                              test_start_in,
    input  wire logic                              printer_enable_in,
    input  wire logic                              recall_in,
    input  wire logic                              hold_release_in,
    input  wire logic [sync_monitor_pkg::RESULT_W-1:0] results_in,
    output logic                                   mark_indicator_out,
    output logic                                   space_indicator_out,
    output logic                                   sync_indicator_out,
    output logic                                   rx_clock_absent_out,
    output logic                                   frame_sync_loss_out,
    output logic                                   display_hold_out,
    output logic                                   print_request_out,
    output logic                                   display_load_out,
    output logic [sync_monitor_pkg::RESULT_W-1:0]  display_data_out,
    output logic                                   not_available_out
);
    import sync_monitor_pkg::*;
    // ==========================================================
    // State
    typedef enum logic [1:0] {MON = 2'b00, CAPT = 2'b01} cap_type;
    typedef struct packed {
        logic                 data_s1;
        logic                 data_s2;
        logic                 clk_s1;
        logic                 clk_s2;
        logic                 clk_s3;
        logic                 mark;
        logic                 space;
        logic                 sync;
        logic [THR_W-1:0]     run;
        logic [IDLE_W-1:0]    idle_cnt;
        logic [CLKLOSS_W-1:0] clk_cnt;
        logic                 clk_abs;
        logic                 frame_loss;
        logic [SNAP_W-1:0]    tick_cnt;
        logic                 wr_ptr;
        cap_type              cap;
        logic                 avail;
        logic                 hold;
        logic                 print;
        logic                 disp_load;
        logic [RESULT_W-1:0]  saved;
        logic [RESULT_W-1:0]  disp_data;
        logic                 not_avail;
    } state_type;
    state_type           st_ff;
    state_type           nxt_st;
    logic [RESULT_W-1:0] hist_rd;
    logic [THR_W-1:0]    threshold;
    logic                snap_wr, clk_edge, idle_expired, loss_event;
    function automatic logic [THR_W-1:0] clamp_thr(input logic [THR_W-1:0] v);
        if (v < BYTE_THR_MIN)
            return BYTE_THR_MIN;
        else if (v > BYTE_THR_MAX)
            return BYTE_THR_MAX;
        else
            return v;
    endfunction
    snapshot_mem #(
        .WIDTH (RESULT_W),
        .DEPTH (HIST_DEPTH),
        .AW    (1)
    ) u_hist (
        .clock_in    (clock_in),
        .wr_en_in    (snap_wr),
        .wr_addr_in  (st_ff.wr_ptr),
        .wr_data_in  (results_in),
        .rd_addr_in  (st_ff.wr_ptr),
        .rd_data_out (hist_rd)
    );
    // ==========================================================
    // Next state
    always_comb
    begin
        nxt_st       = st_ff;
        threshold    = whole_pattern_threshold_in ? pattern_length_in
                                                  : clamp_thr(user_pattern_sync_threshold_in);
        clk_edge     = st_ff.clk_s2 & ~st_ff.clk_s3;
        idle_expired = 1'b0;
        loss_event   = 1'b0;
        snap_wr      = 1'b0;
        nxt_st.data_s1 = rx_data_in;
        nxt_st.data_s2 = st_ff.data_s1;
        nxt_st.clk_s1  = rx_clock_in;
        nxt_st.clk_s2  = st_ff.clk_s1;
        nxt_st.clk_s3  = st_ff.clk_s2;
        nxt_st.mark    = st_ff.data_s2;
        nxt_st.space   = ~st_ff.data_s2;
        // Idle data timer, only armed in async mode with timeout on
        if (!(async_mode_in && idle_data_timeout_in) || rx_char_in)
        begin
            nxt_st.idle_cnt = '0;
        end
        else if (st_ff.idle_cnt == IDLE_W'(IDLE_LIMIT - 1))
        begin
            idle_expired    = 1'b1;
            nxt_st.idle_cnt = '0;
        end
        else
        begin
            nxt_st.idle_cnt = st_ff.idle_cnt + 1'b1;
        end
        // Receive clock activity timer
        nxt_st.frame_loss = 1'b0;
        if (!clock_required_in || clk_edge)
        begin
            nxt_st.clk_cnt = '0;
            nxt_st.clk_abs = 1'b0;
        end
        else if (st_ff.clk_cnt == CLKLOSS_W'(CLK_LIMIT - 1))
        begin
            nxt_st.clk_abs    = 1'b1;
            nxt_st.frame_loss = ~st_ff.clk_abs;
        end
        else
        begin
            nxt_st.clk_cnt = st_ff.clk_cnt + 1'b1;
        end
        // Pattern sync
        if (nxt_st.clk_abs || idle_expired)
        begin
            nxt_st.sync = 1'b0;
            nxt_st.run  = '0;
        end
        else if (user_sync_mode_in)
        begin
            if (byte_valid_in && byte_error_in)
            begin
                nxt_st.sync = 1'b0;
                nxt_st.run  = '0;
            end
            else if (byte_valid_in && !st_ff.sync)
            begin
                nxt_st.run  = st_ff.run + 1'b1;
                nxt_st.sync = (st_ff.run + 1'b1) >= threshold;
            end
        end
        else
        begin
            nxt_st.sync = pattern_sync_in;
            nxt_st.run  = '0;
        end
        loss_event = (st_ff.sync & ~nxt_st.sync) | power_loss_in;
        // Snapshot history every period, skipped in CAPT or on a loss cycle
        if (st_ff.tick_cnt == SNAP_W'(SNAP_LIMIT - 1))
        begin
            nxt_st.tick_cnt = '0;
            snap_wr         = (st_ff.cap == MON) & ~loss_event;
            nxt_st.wr_ptr   = snap_wr ? ~st_ff.wr_ptr : st_ff.wr_ptr;
        end
        else
        begin
            nxt_st.tick_cnt = st_ff.tick_cnt + 1'b1;
        end
        // Loss capture, hold and print
        nxt_st.print     = 1'b0;
        nxt_st.disp_load = 1'b0;
        nxt_st.not_avail = 1'b0;
        case (st_ff.cap)
            MON:
            begin
                if (loss_event)
                begin
                    nxt_st.cap   = CAPT;
                    nxt_st.hold  = 1'b1;
                    nxt_st.print = printer_enable_in;
                end
            end
            CAPT:
            begin
                nxt_st.saved = hist_rd;
                nxt_st.avail = 1'b1;
                nxt_st.cap   = MON;
            end
            default:
                nxt_st.cap = MON;
        endcase
        if (hold_release_in && !(loss_event && st_ff.cap == MON))
            nxt_st.hold = 1'b0;
        if (test_start_in && st_ff.cap == MON)
            nxt_st.avail = 1'b0;
        if (recall_in)
        begin
            if (st_ff.avail)
            begin
                nxt_st.disp_data = st_ff.saved;
                nxt_st.disp_load = 1'b1;
            end
            else
            begin
                nxt_st.not_avail = 1'b1;
            end
        end
    end
    always_ff @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            st_ff           <= '0;
            st_ff.cap       <= MON;
            st_ff.saved     <= RESULT_RESET;
            st_ff.disp_data <= RESULT_RESET;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end
    // ==========================================================
    // Outputs
    assign mark_indicator_out  = st_ff.mark;
    assign space_indicator_out = st_ff.space;
    assign sync_indicator_out  = st_ff.sync;
    assign rx_clock_absent_out = st_ff.clk_abs;
    assign frame_sync_loss_out = st_ff.frame_loss;
    assign display_hold_out    = st_ff.hold;
    assign print_request_out   = st_ff.print;
    assign display_load_out    = st_ff.disp_load;
    assign display_data_out    = st_ff.disp_data;
    assign not_available_out   = st_ff.not_avail;
    // ==========================================================
    // Assertions
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rstn_in);

    a_mark_space_excl: assert property (!(mark_indicator_out && space_indicator_out))
        else $error("mark and space both on");
    a_mark_follows: assert property (st_ff.data_s2 |=> mark_indicator_out)
        else $error("mark not set on one");
    a_space_follows: assert property (!st_ff.data_s2 |=> space_indicator_out)
        else $error("space not set on zero");
    a_clk_absent_sync: assert property (rx_clock_absent_out |-> !sync_indicator_out)
        else $error("sync held with clock absent");
    a_clk_absent_frame: assert property ($rose(rx_clock_absent_out) |-> frame_sync_loss_out)
        else $error("no frame loss on clock loss");
    a_clk_edge_clears: assert property (clk_edge |=> !rx_clock_absent_out)
        else $error("clock absent despite edge");
    a_idle_off_quiet: assert property (!(async_mode_in && idle_data_timeout_in) |=> st_ff.idle_cnt == '0)
        else $error("idle loss with timeout off");
    a_idle_forces_loss: assert property (idle_expired |=> !sync_indicator_out)
        else $error("idle expiry kept sync");
    a_user_err_drops: assert property (user_sync_mode_in && byte_valid_in && byte_error_in
                                       |=> !sync_indicator_out)
        else $error("errored byte kept sync");
    a_loss_hold_print: assert property (loss_event && st_ff.cap == MON
                                        |=> display_hold_out && (print_request_out == $past(printer_enable_in)))
        else $error("loss did not hold or print");
    a_recall_none: assert property (recall_in && !st_ff.avail |=> not_available_out && !display_load_out)
        else $error("recall without results");
    a_recall_load: assert property (recall_in && st_ff.avail |=> display_load_out
                                    && display_data_out == $past(st_ff.saved))
        else $error("recall did not load snapshot");

    c_user_sync: cover property (user_sync_mode_in && $rose(sync_indicator_out));
    c_clock_loss: cover property ($rose(rx_clock_absent_out));
    c_idle_loss: cover property (idle_expired);
    c_recall_ok: cover property (display_load_out);
endmodule
`default_nettype wire

// ### line_model.sv
// Partner model: serial line under test with its receive clock
`timescale 1ns/100ps
`default_nettype none
module line_model (
    input  wire logic clock_in,
    input  wire logic clk_run_in,
    input  wire logic bit_in,
    input  wire logic char_in,
    output logic      rx_data_out,
    output logic      rx_clock_out,
    output logic      rx_char_out
);
    logic [1:0] div_ff;
    initial
    begin
        div_ff = 2'h0;
        rx_clock_out = 1'b0;
    end
    // Line clock toggles every fourth cycle, stands still while clk_run_in is low
    always @(posedge clock_in)
    begin
        div_ff <= div_ff + 2'h1;
        if (clk_run_in && div_ff == 2'h3)
            rx_clock_out <= ~rx_clock_out;
    end
    assign rx_data_out = bit_in;
    assign rx_char_out = char_in;
endmodule
`default_nettype wire

// ### receive_sync_monitor_tb.sv
// Self-checking bench for the receive sync monitor
`timescale 1ns/100ps
`default_nettype none
module receive_sync_monitor_tb;
    import sync_monitor_pkg::*;
    logic clock_in, rstn_in, rxd, rxc, rxk, bv, be, um, wp, ps, am, it, cr, pe, run, bitv;
    logic mk, sp, sy, ab, fl, dh, pr, dl, na, sq;
    logic [4:0]  pv;
    logic [11:0] thr, plen;
    logic [31:0] res, dd, rv;
    int bad_count, checks, cyc, pr_n, fl_n, dl_n, na_n, sf_n, n, i, k, p0, s0;
    line_model line (.clock_in(clock_in), .clk_run_in(run), .bit_in(bitv), .char_in(pv[4]),
        .rx_data_out(rxd), .rx_clock_out(rxc), .rx_char_out(rxk));
    receive_sync_monitor #(.IDLE_LIMIT(200), .CLK_LIMIT(50), .SNAP_LIMIT(20)) uut (
        .clock_in(clock_in), .rstn_in(rstn_in), .rx_data_in(rxd), .rx_clock_in(rxc),
        .rx_char_in(rxk), .byte_valid_in(bv), .byte_error_in(be), .user_sync_mode_in(um),
        .whole_pattern_threshold_in(wp), .user_pattern_sync_threshold_in(thr),
        .pattern_length_in(plen), .pattern_sync_in(ps), .async_mode_in(am),
        .idle_data_timeout_in(it), .clock_required_in(cr), .power_loss_in(pv[3]),
        .test_start_in(pv[2]), .printer_enable_in(pe), .recall_in(pv[0]),
        .hold_release_in(pv[1]), .results_in(res), .mark_indicator_out(mk),
        .space_indicator_out(sp), .sync_indicator_out(sy), .rx_clock_absent_out(ab),
        .frame_sync_loss_out(fl), .display_hold_out(dh), .print_request_out(pr),
        .display_load_out(dl), .display_data_out(dd), .not_available_out(na));
    // ==========================================================
    // Shared tasks
    task end_sim;
        if (bad_count == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Clean bytes needed for a byte-count threshold setting
    function automatic int byte_need(input logic [11:0] t);
        if (t < BYTE_THR_MIN)
            return int'(BYTE_THR_MIN);
        else if (t > BYTE_THR_MAX)
            return int'(BYTE_THR_MAX);
        return int'(t);
    endfunction
    task tk;
        @(posedge clock_in);
        #1;
    endtask
    task automatic w(input int c);
        repeat (c) tk;
    endtask
    task automatic pulse(input int b);
        pv[b] = 1'b1;
        tk;
        pv[b] = 1'b0;
        tk;
    endtask
    task automatic by(input logic e);
        bv = 1'b1;
        be = e;
        tk;
        bv = 1'b0;
        be = 1'b0;
        tk;
    endtask
    // Retries once if display hold is still off after the first loss
    task automatic loss(input logic pw);
        repeat (2)
            if (dh !== 1'b1)
            begin
                if (pw)
                    pulse(3);
                else
                begin
                    ps = 1'b1;
                    w(3);
                    ps = 1'b0;
                end
                w(4);
            end
    endtask
    // ==========================================================
    // Clock, event counters and timeout
    initial
    begin
        clock_in = 1'b0;
        forever #20 clock_in = ~clock_in;
    end
    always @(negedge clock_in)
    begin
        cyc++;
        pr_n += pr;
        fl_n += fl;
        dl_n += dl;
        na_n += na;
        if (sq === 1'b1 && sy === 1'b0)
            sf_n++;
        sq = sy;
        if (cyc > 20000)
        begin
            bad_count++;
            end_sim;
        end
    end
    // ==========================================================
    // Main sequence
    initial
    begin
        rstn_in = 1'b0;
        {bv, be, um, wp, ps, am, it, cr, pe, run, bitv} = '0;
        pv = '0;
        thr = 12'h00a;
        plen = 12'h004;
        res = '0;
        void'($urandom(32'hdcb951a1));
        repeat (12) @(posedge clock_in);
        #1 rstn_in = 1'b1;
        tk;
        pulse(0);
        w(2);
        chk("not_avail", 32'(na_n), 1);
        for (i = 0; i < 20; i++)
        begin
            bitv = 1'($urandom);
            w(4);
            chk("mark", mk, bitv);
            chk("space", sp, !bitv);
            chk("both", mk & sp, 0);
        end
        um = 1'b1;
        for (k = 0; k < 2; k++)
        begin
            thr = k ? 12'(10 + $urandom % 8) : 12'h005;
            n = byte_need(thr);
            by(1'b1);
            repeat (n - 1) by(1'b0);
            w(2);
            chk("sync_early", sy, 0);
            by(1'b0);
            w(1);
            chk("sync_bytes", sy, 1);
        end
        by(1'b1);
        chk("sync_err", sy, 0);
        wp = 1'b1;
        thr = 12'h800;
        n = 3 + $urandom % 10;
        plen = 12'(n);
        by(1'b1);
        repeat (n - 1) by(1'b0);
        w(2);
        chk("sync_early", sy, 0);
        by(1'b0);
        w(1);
        chk("sync_whole", sy, 1);
        um = 1'b0;
        wp = 1'b0;
        ps = 1'b1;
        w(2);
        by(1'b1);
        w(1);
        chk("sync_other", sy, 1);
        rv = $urandom;
        res = rv;
        pe = 1'b1;
        w(100);
        pulse(1);
        chk("hold_rel", dh, 0);
        p0 = pr_n;
        loss(1'b0);
        chk("hold", dh, 1);
        chk("print", 32'(pr_n - p0), 1);
        res = ~rv;
        pulse(0);
        w(2);
        chk("load", 32'(dl_n), 1);
        chk("snap", dd, rv);
        pulse(1);
        pe = 1'b0;
        p0 = pr_n;
        loss(1'b1);
        chk("hold_pwr", dh, 1);
        chk("no_print", 32'(pr_n - p0), 0);
        pulse(2);
        pulse(0);
        w(2);
        chk("not_avail", 32'(na_n), 2);
        ps = 1'b1;
        cr = 1'b1;
        run = 1'b1;
        w(30);
        chk("absent", ab, 0);
        p0 = fl_n;
        s0 = sf_n;
        run = 1'b0;
        w(38);
        chk("absent", ab, 0);
        w(25);
        chk("absent", ab, 1);
        chk("frame_loss", 32'(fl_n - p0), 1);
        chk("sync_loss", 32'(sf_n - s0), 1);
        run = 1'b1;
        w(20);
        chk("absent", ab, 0);
        run = 1'b0;
        cr = 1'b0;
        w(80);
        chk("absent", ab, 0);
        am = 1'b1;
        it = 1'b1;
        w(5);
        s0 = sf_n;
        pulse(4);
        w(190);
        chk("idle", 32'(sf_n - s0), 0);
        pulse(4);
        w(190);
        chk("idle", 32'(sf_n - s0), 0);
        w(30);
        chk("idle", 32'(sf_n - s0), 1);
        it = 1'b0;
        s0 = sf_n;
        w(450);
        chk("idle_off", 32'(sf_n - s0), 0);
        end_sim;
    end
endmodule
`default_nettype wire
